// file: sdcr_pkg.sv
// sdcr_pkg: constants, types and helpers for the start detect / clock recovery block.
// assumes a single core clock; all timing is counted in oversample ticks.
package sdcr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clocking and oversampling
    localparam int unsigned CLK_HZ_DEFAULT = 40_000_000;
    localparam int unsigned OVERSAMPLE = 16;
    localparam int DIV_W = 12;

    // printed bit rates, indexed by the latched rate code
    localparam int unsigned RATE_BPS [4] = '{2400, 4800, 9600, 19200};

    ////////////////////////////////////////////////////////////////////////////
    // preamble and pulse timing, in ticks
    localparam int unsigned PREAMBLE_LOW_BITS = 8;
    localparam int RUN_W = 8;
    localparam logic [RUN_W-1:0] LOW_RUN_TICKS = 8'(PREAMBLE_LOW_BITS * OVERSAMPLE);
    // 1.25 bit periods: inside the 1 to 1.5 bit window with margin both ways
    localparam int PULSE_W = 5;
    localparam logic [PULSE_W-1:0] PULSE_TICKS = 5'h14;

    ////////////////////////////////////////////////////////////////////////////
    // bit phase tracking
    localparam int PHASE_W = 4;
    localparam logic [PHASE_W-1:0] PHASE_EDGE = 4'h0;
    localparam logic [PHASE_W-1:0] PHASE_AFTER_EDGE = 4'h1;
    localparam logic [PHASE_W-1:0] PHASE_MID = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // types
    // rate code is {rate_select_high, rate_select_low}
    typedef enum logic [1:0] {
        SDCR_RATE_2400 = 2'h0,
        SDCR_RATE_4800 = 2'h1,
        SDCR_RATE_9600 = 2'h2,
        SDCR_RATE_19200 = 2'h3
    } sdcr_rate_t;

    typedef struct packed {
        logic rate_select_high;
        logic rate_select_low;
    } sdcr_rate_pins_t;

    typedef struct packed {
        logic start_of_frame_pulse;
        logic recovered_bit_strobe;
    } sdcr_frame_out_t;

    // core clocks per oversample tick for a rate code
    function automatic int unsigned sdcr_tick_div(input int unsigned clk_hz,
                                                  input logic [1:0] code);
        sdcr_tick_div = clk_hz / (RATE_BPS[code] * OVERSAMPLE);
    endfunction

endpackage

// file: sdcr_clock_recovery.sv
// sdcr_clock_recovery: preamble hunter and oversampled bit strobe generator.
// assumes received_serial_input is already inverted and synchronous to core_clk;
// rate pins are strapped and only looked at once after reset release.
//
// Functional notes
// R1: four bit rates; the two rate select pins choose the extraction rate.
// R2: rate pins sampled once after reset; new rate needs a full reset.
// R3: {high,low} 00=2400, 01=4800, 10=9600, 11=19200 bps.
// R4: preamble is eight low bit periods then eight alternating bits, high first.
// R5: start pulse fires after input stays low for eight bit periods.
// R6: start pulse is active high, between one and 1.5 bit periods long.
// R7: first valid bit is the first strobe after the start pulse falls.
// R8: one strobe near each bit middle, from an oversampled phase tracking loop.
// R9: after the preamble, data edges keep the strobe centred on the average middle.
// R10: preamble hunt runs forever and tolerates noise between transmissions.
// R11: sender should follow the low run with the alternating training bits.
// R12: no end of frame detection; length lives in the payload.
// R13: payload should be DC balanced over 16 bits with frequent edges.
// R14: payload uses 12-bit symbols holding six ones and six zeros.
// R15: sender should keep every run within 1% of the nominal bit period.
// R16: host sends inverted data and reads the same line as this block.
// R17: input sampled at sixteen ticks per bit; runs and phase counted in ticks.
// R18: any later eight-bit low run retriggers the pulse and realigns strobes.
`timescale 1ns/1ps
`default_nettype none

module sdcr_clock_recovery #(
    parameter int unsigned CLK_HZ = sdcr_pkg::CLK_HZ_DEFAULT
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic received_serial_input,
    input wire sdcr_pkg::sdcr_rate_pins_t rate_pins,
    output var sdcr_pkg::sdcr_frame_out_t frame_out,
    output var sdcr_pkg::sdcr_rate_t active_rate
);
    import sdcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // elaboration check: the divider must fit and give at least two clocks a tick
    if (sdcr_tick_div(CLK_HZ, 2'h3) < 2 || sdcr_tick_div(CLK_HZ, 2'h0) >= (1 << DIV_W)) begin : g_chk
        $error("sdcr_clock_recovery: CLK_HZ cannot serve the supported bit rates");
    end

    typedef enum logic [1:0] {
        ST_HUNT,
        ST_ALIGN,
        ST_TRACK
    } sdcr_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic rate_taken_reg;
    sdcr_rate_t rate_reg;
    logic [DIV_W-1:0] div_cnt_reg;
    logic [DIV_W-1:0] div_cnt_next;
    logic [2:0] hist_reg;
    logic level_reg;
    logic [RUN_W-1:0] low_run_reg;
    logic [RUN_W-1:0] low_run_next;
    logic [PULSE_W-1:0] pulse_cnt_reg;
    logic [PULSE_W-1:0] pulse_cnt_next;
    logic [PHASE_W-1:0] phase_reg;
    logic [PHASE_W-1:0] phase_next;
    sdcr_state_t state_reg;
    sdcr_state_t state_next;
    sdcr_frame_out_t out_reg;
    sdcr_frame_out_t out_next;

    ////////////////////////////////////////////////////////////////////////////
    // decode of the rate pins and the tick divider
    wire logic [1:0] pin_code_w = {rate_pins.rate_select_high, rate_pins.rate_select_low}; // [R3]
    wire logic [DIV_W-1:0] div_limit_w = DIV_W'(sdcr_tick_div(CLK_HZ, rate_reg) - 1); // [R1]
    wire logic tick_w = rate_taken_reg && (div_cnt_reg == div_limit_w); // [R17]

    // rate strap capture: once, on the first edge after reset release
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rate_taken_reg <= 1'b0;
            rate_reg <= SDCR_RATE_2400;
        end else if (!rate_taken_reg) begin
            rate_taken_reg <= 1'b1; // [R2]
            rate_reg <= sdcr_rate_t'(pin_code_w); // [R1] [R3]
        end
    end

    // divider holds at zero until the rate is known, so ticks never use a stale rate
    assign div_cnt_next = (!rate_taken_reg || tick_w) ? '0 : div_cnt_reg + 1'b1;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input sampling with a three tick majority vote
    // the vote costs one tick of latency on every edge but drops single tick
    // noise spikes that would otherwise break a low run between transmissions
    wire logic [2:0] vote_w = {hist_reg[1:0], received_serial_input};
    wire logic filt_w = (vote_w[0] & vote_w[1]) | (vote_w[1] & vote_w[2])
                        | (vote_w[0] & vote_w[2]); // [R10]
    wire logic edge_w = tick_w && (filt_w != level_reg); // [R17]
    wire logic rise_w = edge_w && filt_w;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            hist_reg <= '0;
            level_reg <= 1'b0;
        end else if (tick_w) begin
            hist_reg <= vote_w; // [R17]
            level_reg <= filt_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // low run counter: counts ticks of steady low, saturating at eight bits
    // saturation means a long idle low fires exactly once per run
    wire logic run_full_w = (low_run_reg == LOW_RUN_TICKS);
    wire logic detect_w = tick_w && !filt_w && (low_run_reg == LOW_RUN_TICKS - 1'b1); // [R5]

    always_comb begin
        low_run_next = low_run_reg;
        if (tick_w) begin
            if (filt_w) begin
                low_run_next = '0; // [R4]
            end else if (!run_full_w) begin
                low_run_next = low_run_reg + 1'b1; // [R5] [R17]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            low_run_reg <= '0;
        end else begin
            low_run_reg <= low_run_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start pulse length counter; a new detection reloads it
    always_comb begin
        pulse_cnt_next = pulse_cnt_reg;
        if (detect_w) begin
            pulse_cnt_next = PULSE_TICKS; // [R6] [R18]
        end else if (tick_w && pulse_cnt_reg != '0) begin
            pulse_cnt_next = pulse_cnt_reg - 1'b1; // [R6]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pulse_cnt_reg <= '0;
        end else begin
            pulse_cnt_reg <= pulse_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame state: hunt for preamble, wait for first training edge, then track
    // there is no exit from tracking except a new preamble, as the frame end
    // is unknown to this block
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_HUNT: begin
                if (detect_w) begin
                    state_next = ST_ALIGN; // [R10]
                end
            end
            ST_ALIGN: begin
                if (rise_w) begin
                    state_next = ST_TRACK; // [R4]
                end
            end
            ST_TRACK: begin
                if (detect_w) begin
                    state_next = ST_ALIGN; // [R18] [R12]
                end
            end
            default: begin
                state_next = ST_HUNT;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_reg <= ST_HUNT;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit phase loop
    // the first rise after the low run hard-aligns phase; later edges nudge it
    // one tick at a time, so a single jittered edge cannot drag the strobe far
    wire logic edge_late_w = (phase_reg != PHASE_EDGE) && !phase_reg[PHASE_W-1];
    wire logic edge_early_w = phase_reg[PHASE_W-1];

    always_comb begin
        phase_next = phase_reg;
        if (tick_w) begin
            if (state_reg == ST_ALIGN && rise_w) begin
                phase_next = PHASE_AFTER_EDGE; // [R9]
            end else if (state_reg == ST_TRACK && edge_w && edge_late_w) begin
                phase_next = phase_reg; // [R9] slows by one tick
            end else if (state_reg == ST_TRACK && edge_w && edge_early_w) begin
                phase_next = phase_reg + 4'h2; // [R9] speeds by one tick
            end else begin
                phase_next = phase_reg + 1'b1; // [R17] wraps at sixteen
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            phase_reg <= PHASE_EDGE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, registered
    // strobe is one core clock wide, on the tick where phase sits mid bit
    always_comb begin
        out_next.start_of_frame_pulse = (pulse_cnt_next != '0); // [R5] [R6]
        out_next.recovered_bit_strobe = tick_w && (state_reg == ST_TRACK)
                                        && (phase_reg == PHASE_MID); // [R8] [R7]
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            out_reg <= '0;
        end else begin
            out_reg <= out_next;
        end
    end

    assign frame_out = out_reg;
    assign active_rate = rate_reg;

endmodule // sdcr_clock_recovery

`default_nettype wire

// file: sdcr_clock_recovery_assertions.sv
// sdcr_checker: port-level checks of the start detect / clock recovery block.
// assumes it is bound onto the top module with the same CLK_HZ.
`timescale 1ns/1ps
`default_nettype none
module sdcr_checker #(
    parameter int unsigned CLK_HZ = 40_000_000
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic received_serial_input,
    input wire sdcr_pkg::sdcr_rate_pins_t rate_pins,
    input wire sdcr_pkg::sdcr_frame_out_t frame_out,
    input wire sdcr_pkg::sdcr_rate_t active_rate
);
    import sdcr_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////
    logic pls;
    logic stb;
    logic seen_p;
    logic realign_q;
    int tick;
    int pw_q;
    int hi_q;
    int lo_q;
    int gap_q;
    // tick length in clocks for the latched rate
    assign pls = frame_out.start_of_frame_pulse;
    assign stb = frame_out.recovered_bit_strobe;
    assign tick = int'((CLK_HZ / 38400) >> active_rate);
    // run counters; a low run only ends on a high longer than a votable spike
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pw_q <= 0;
            hi_q <= 0;
            lo_q <= 0;
            gap_q <= 1000000;
            seen_p <= 1'b0;
            realign_q <= 1'b0;
        end else begin
            // a new detection restarts alignment, so the next strobe may sit close to the last
            realign_q <= (pls && pw_q == 0) ? 1'b1 : (stb ? 1'b0 : realign_q);
            pw_q <= pls ? pw_q + 1 : 0;
            hi_q <= received_serial_input ? hi_q + 1 : 0;
            lo_q <= (received_serial_input && hi_q >= 2 * tick) ? 0 : lo_q + 1;
            gap_q <= stb ? 0 : gap_q + 1;
            seen_p <= seen_p | pls;
        end
    end
    ////////////////////////////////////////////////////////////
    sequence s_pulse_end;
        pls ##1 !pls;
    endsequence
    sequence s_strobe_once;
        stb ##1 !stb;
    endsequence
    rate_capture_a: assert property ($rose(rstn) |=> 2'(active_rate) == 2'($past(rate_pins)))
        else $error("latched rate differs from strap");
    rate_hold_a: assert property (rstn && $past(rstn) && $past(rstn, 2) |-> $stable(active_rate))
        else $error("rate changed without reset");
    pulse_min_a: assert property (s_pulse_end |-> pw_q >= 16 * tick)
        else $error("start pulse too short");
    pulse_max_a: assert property (pls |-> pw_q < 24 * tick)
        else $error("start pulse too long");
    pulse_low_run_a: assert property ($rose(pls) |-> lo_q >= 124 * tick)
        else $error("start pulse without long low run");
    strobe_single_a: assert property (stb |-> s_strobe_once)
        else $error("strobe wider than one clock");
    strobe_spacing_a: assert property (stb && !realign_q |-> gap_q >= 13 * tick)
        else $error("strobes too close");
    strobe_after_det_a: assert property (stb |-> seen_p)
        else $error("strobe before any detection");
endmodule // sdcr_checker
`default_nettype wire

// file: sdcr_radio_model.sv
// sdcr_radio_model: sliced and inverted radio line feeding the recovery block.
// assumes the caller gives the bit period in core clocks; holds the last bit between sends.
`timescale 1ns/1ps
`default_nettype none
module sdcr_radio_model (
    input wire logic core_clk,
    output var logic rx_line
);
    int in_bit = 0;
    logic in_frame = 1'b0;
    initial rx_line = 1'b1;
    // msb first; runs are whole bit periods, exact to the clock
    task automatic send(input logic [31:0] pat, input int n, input int bclk, input logic framed);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge core_clk);
            rx_line <= pat[i];
            in_frame <= framed;
            in_bit <= 0;
            repeat (bclk - 1) begin
                @(posedge core_clk);
                in_bit <= in_bit + 1;
            end
        end
    endtask
endmodule // sdcr_radio_model
`default_nettype wire

// file: sdcr_clock_recovery_tb.sv
// sdcr_clock_recovery_tb: self-checking bench for the recovery block.
// assumes a reduced CLK_HZ so ticks are 32/16/8/4 clocks for the four rates.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module sdcr_clock_recovery_tb;
    import sdcr_pkg::*;
    localparam int unsigned CLK_HZ = 1_228_800;
    localparam int LIMIT = 60000;
    logic core_clk;
    logic rstn;
    logic rx;
    logic prev_p;
    sdcr_rate_pins_t pins;
    sdcr_frame_out_t fo;
    sdcr_rate_t rate;
    int fails, checks, cyc, n_pulse, n_strobe, t_rise, t_low, last_w, tk;
    sdcr_clock_recovery #(.CLK_HZ(CLK_HZ)) DUT (.core_clk(core_clk), .rstn(rstn),
        .received_serial_input(rx), .rate_pins(pins), .frame_out(fo), .active_rate(rate));
    sdcr_radio_model radio (.core_clk(core_clk), .rx_line(rx));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic test_done();
        if (fails == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // pulse and strobe watcher; strobes must sit near mid-bit inside frames
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (fo.start_of_frame_pulse === 1'b1 && prev_p !== 1'b1) begin
            n_pulse++;
            t_rise = cyc;
        end
        if (fo.start_of_frame_pulse === 1'b0 && prev_p === 1'b1) last_w = cyc - t_rise;
        prev_p = fo.start_of_frame_pulse;
        if (fo.recovered_bit_strobe === 1'b1 && radio.in_frame) begin
            n_strobe++;
            `CHK(radio.in_bit >= 4 * tk && radio.in_bit <= 12 * tk, 1'b1)
        end
        if (cyc == LIMIT) begin
            fails++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic do_reset(input logic [1:0] code);
        rstn <= 1'b0;
        pins <= code;
        repeat (3) @(posedge core_clk);
        `CHK({fo, rate}, 4'h0)
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        tk = 32 >> code;
    endtask
    // strap each code, then move the pins and expect no change
    task automatic t_rate(input logic [1:0] code);
        do_reset(code);
        `CHK(2'(rate), code)
        pins <= ~code;
        repeat (4) @(posedge core_clk);
        `CHK(2'(rate), code)
    endtask
    // low run then training; pulse must rise after 128 ticks and last 16..24
    task automatic t_preamble();
        int n0;
        n0 = n_pulse;
        t_low = cyc + 1;
        radio.send(32'h0, 8, 16 * tk, 1'b0);
        radio.send(32'hAA, 8, 16 * tk, 1'b1);
        `CHK(n_pulse, n0 + 1)
        `CHK(t_rise - t_low >= 128 * tk && t_rise - t_low <= 132 * tk, 1'b1)
        `CHK(last_w >= 16 * tk && last_w <= 24 * tk, 1'b1)
    endtask
    // noise, frame, payload, retrigger mid-stream and more payload
    task automatic t_frame(input logic [1:0] code);
        int n0;
        do_reset(code);
        n0 = n_pulse;
        radio.send(32'h5B3A_96D5, 32, 16 * tk, 1'b0);
        `CHK(n_pulse, n0)
        t_preamble();
        n0 = n_strobe;
        radio.send(32'h5A55A5, 24, 16 * tk, 1'b1);
        `CHK(n_strobe - n0, 24)
        t_preamble();
        n0 = n_strobe;
        radio.send(32'h5A5, 12, 16 * tk, 1'b1);
        `CHK(n_strobe - n0, 12)
    endtask
    initial begin
        rstn = 1'b0;
        pins = '0;
        prev_p = 1'b0;
        for (int c = 0; c < 4; c++) t_rate(2'(c));
        t_frame(2'h3);
        t_frame(2'h1);
        test_done();
    end
endmodule // sdcr_clock_recovery_tb
bind sdcr_clock_recovery sdcr_checker #(.CLK_HZ(CLK_HZ)) u_chk (.core_clk(core_clk),
    .rstn(rstn), .received_serial_input(received_serial_input), .rate_pins(rate_pins),
    .frame_out(frame_out), .active_rate(active_rate));
`default_nettype wire
